// ---- core/gspc_defines.vh ----
/*
 pin function configuration block: offsets, field positions, reset
 values and mode codes as macros.
 assumes: included by bare name from the core design files.
*/
`ifndef GSPC_DEFINES_VH
`define GSPC_DEFINES_VH

`define GSPC_ADDR_W          6
`define GSPC_REG_ADDR        6'h06
`define GSPC_REG_RESET       16'h0800
`define GSPC_REG_RW_MASK     16'h3fc0
`define GSPC_BIT_OUT_EN      13
`define GSPC_BIT_OPEN_WIRE_DETECT_ENABLE       12
`define GSPC_BIT_SYNC_EN     11
`define GSPC_ERR_MODE_HI     10
`define GSPC_ERR_MODE_LO     9
`define GSPC_BIT_ERROR_PIN_DATA     8
`define GSPC_BIT_GP1         7
`define GSPC_BIT_GP0         6
`define GSPC_ERR_OFF         2'h0
`define GSPC_ERR_IN          2'h1
`define GSPC_ERR_OD          2'h2
`define GSPC_ERR_GPO         2'h3

`endif

// ---- core/gspc_pin_config.v ----
/*
 pin function configuration register with general outputs, open-wire
 enable, sync control and error pin modes.
 assumes: host register port gives one-cycle read/write strobes with a
 6-bit address; error pin wire is resolved outside from data/enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gspc_defines.vh"

// Contract
// - general outputs driven only when enabled
// - open-wire detection only when enabled
// - low sync holds modulator in reset
// - alt mode: low sync stalls next conversion
// - alt mode needs several enabled channels
// - rising sync starts held conversion
// - error mode field decoded, 00 off
// - mode 01: inverted pin ORed into error
// - mode 10: open-drain active-low error output
// - mode 11: pin is general output, pull-up
// - output mode drives error data bit
// - input mode reads pin into data bit
// - bit 7 drives general output one
// - bit 6 drives general output zero
module gspc_pin_config (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        RESET_N_I,
  // register port
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  input  wire [5:0]  REG_ADDR_I,
  input  wire [15:0] REG_WDATA_I,
  output reg  [15:0] REG_RDATA_O,
  output reg         REG_RVALID_O,
  // configuration from other registers and sequencer
  input  wire        ALTERNATIVE_SYNC_SELECT_SELECT_I,
  input  wire        MULTI_CHAN_I,
  input  wire        SWITCH_DUE_I,
  input  wire        INT_ERROR_I,
  input  wire        STATUS_ERRORS_I,
  // sync pin
  input  wire        SYNC_N_I,
  // error pin (four signals)
  input  wire        ERROR_PIN_I,
  output reg         ERROR_PIN_O,
  output reg         ERROR_PIN_OE_O,
  output reg         ERROR_PULLUP_O,
  // general outputs
  output reg         GENERAL_OUTPUT_ZERO_O,
  output reg         GENERAL_OUTPUT_ONE_O,
  output reg         GENERAL_OUTPUT_EN_O,
  // to converter core
  output reg         OPEN_WIRE_DETECT_EN_O,
  output reg         ADC_ERROR_O,
  output wire        MOD_RESET_O,
  output wire        CONV_START_O,
  output wire        CONV_HOLD_O
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function is_mode;
    input [1:0] field;
    input [1:0] code;
    begin
      is_mode = (field == code);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  // cfg_q keeps only the writable bits; reserved
  // positions are forced to zero on every write
  reg  [15:0] cfg_q;
  reg         err_pin_q;
  wire [1:0]  err_mode;
  wire        hit;
  wire [15:0] rd_view;

  assign err_mode = cfg_q[`GSPC_ERR_MODE_HI:`GSPC_ERR_MODE_LO];
  assign hit      = (REG_ADDR_I == `GSPC_REG_ADDR);

  // ----------------------------------------
  // register
  // ----------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      cfg_q     <= `GSPC_REG_RESET;
      // idle level of the pulled-up pin; a zero here
      // would flag no error, since reset loads error mode 00
      err_pin_q <= 1'b1;
    end else begin
      // sampled every cycle; pin is synchronous
      err_pin_q <= ERROR_PIN_I;
      if (REG_WR_I && hit) begin
        cfg_q <= REG_WDATA_I & `GSPC_REG_RW_MASK;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // pin level in input mode
  assign rd_view = is_mode(err_mode, `GSPC_ERR_IN) ?
                   {cfg_q[15:9], err_pin_q, cfg_q[7:0]} : cfg_q;

  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O  <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      // unmapped addresses read zero
      REG_RDATA_O  <= (REG_RD_I && hit) ? rd_view : 16'h0000;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      GENERAL_OUTPUT_ZERO_O <= 1'b0;
      GENERAL_OUTPUT_ONE_O  <= 1'b0;
      GENERAL_OUTPUT_EN_O   <= 1'b0;
      OPEN_WIRE_DETECT_EN_O <= 1'b0;
      ERROR_PIN_O           <= 1'b0;
      ERROR_PIN_OE_O        <= 1'b0;
      ERROR_PULLUP_O        <= 1'b0;
      ADC_ERROR_O           <= 1'b0;
    end else begin
      GENERAL_OUTPUT_EN_O   <= cfg_q[`GSPC_BIT_OUT_EN];
      GENERAL_OUTPUT_ZERO_O <= cfg_q[`GSPC_BIT_OUT_EN] & cfg_q[`GSPC_BIT_GP0];
      GENERAL_OUTPUT_ONE_O  <= cfg_q[`GSPC_BIT_OUT_EN] & cfg_q[`GSPC_BIT_GP1];
      OPEN_WIRE_DETECT_EN_O <= cfg_q[`GSPC_BIT_OPEN_WIRE_DETECT_ENABLE];
      // two-cycle lag from the pin: one sample stage,
      // one output stage, both plain flops
      // pin low adds error
      ADC_ERROR_O <= INT_ERROR_I |
                     (is_mode(err_mode, `GSPC_ERR_IN) & ~err_pin_q);
      case (err_mode)
        `GSPC_ERR_OD: begin
          // pull low on any error; never drive high
          ERROR_PIN_O    <= 1'b0;
          ERROR_PIN_OE_O <= STATUS_ERRORS_I;
          ERROR_PULLUP_O <= 1'b0;
        end
        `GSPC_ERR_GPO: begin
          ERROR_PIN_O    <= cfg_q[`GSPC_BIT_ERROR_PIN_DATA];
          ERROR_PIN_OE_O <= 1'b1;
          ERROR_PULLUP_O <= 1'b1;
        end
        default: begin
          ERROR_PIN_O    <= 1'b0;
          ERROR_PIN_OE_O <= 1'b0;
          ERROR_PULLUP_O <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sync handling
  // ----------------------------------------
  // sync pin goes straight in; it is taken as
  // synchronous, so no extra stage is added here
  gspc_sync_ctrl u_sync (
    .clk_i        (CLOCK_I),
    .rst_n_i      (RESET_N_I),
    .sync_en_i    (cfg_q[`GSPC_BIT_SYNC_EN]),
    .alternative_sync_select_i   (ALTERNATIVE_SYNC_SELECT_SELECT_I),
    .multi_chan_i (MULTI_CHAN_I),
    .sync_n_i     (SYNC_N_I),
    .switch_due_i (SWITCH_DUE_I),
    .mod_reset_o  (MOD_RESET_O),
    .conv_start_o (CONV_START_O),
    .conv_hold_o  (CONV_HOLD_O)
  );

endmodule

`default_nettype wire

// ---- core/gspc_sync_ctrl.v ----
/*
 sync pin handling: plain hold-in-reset mode and the alternative mode that
 only stalls the start of a conversion at a channel switch.
 assumes: sync pin and sequencer strobes synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gspc_sync_ctrl (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // configuration
  input  wire       sync_en_i,
  input  wire       alternative_sync_select_i,
  input  wire       multi_chan_i,
  // pin and sequencer
  input  wire       sync_n_i,
  input  wire       switch_due_i,
  // results
  output reg        mod_reset_o,
  output reg        conv_start_o,
  output reg        conv_hold_o
);

  reg  hold_q;
  reg  hold_d;
  wire alt_active;
  wire start_d;

  assign alt_active = sync_en_i & alternative_sync_select_i & multi_chan_i;

  always @* begin
    hold_d = hold_q;
    if (!alt_active) begin
      hold_d = 1'b0;
    end else if (hold_q && sync_n_i) begin
      hold_d = 1'b0;
    end else if (switch_due_i && !sync_n_i) begin
      hold_d = 1'b1;
    end
  end

  assign start_d = alt_active ? ((hold_q & sync_n_i) | (switch_due_i & sync_n_i))
                              : (switch_due_i & ~(sync_en_i & ~sync_n_i));

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_q       <= 1'b0;
      mod_reset_o  <= 1'b0;
      conv_start_o <= 1'b0;
      conv_hold_o  <= 1'b0;
    end else begin
      hold_q       <= hold_d;
      mod_reset_o  <= sync_en_i & ~alt_active & ~sync_n_i;
      conv_start_o <= start_d;
      conv_hold_o  <= hold_d;
    end
  end

endmodule

`default_nettype wire

// ---- dv/gspc_pin_config_sva.sv ----
/*
 checker for the pin function configuration block ports.
 assumes: bound to the core top from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module gspc_pin_config_sva (
  input wire logic        CLOCK_I, RESET_N_I, REG_RD_I, REG_RVALID_O, SYNC_N_I,
  input wire logic        ALTERNATIVE_SYNC_SELECT_SELECT_I, MULTI_CHAN_I, SWITCH_DUE_I, INT_ERROR_I,
  input wire logic        ERROR_PIN_I, ERROR_PIN_O, ERROR_PIN_OE_O, ERROR_PULLUP_O,
  input wire logic        GENERAL_OUTPUT_ZERO_O, GENERAL_OUTPUT_ONE_O, GENERAL_OUTPUT_EN_O,
  input wire logic        ADC_ERROR_O, MOD_RESET_O, CONV_START_O, CONV_HOLD_O,
  input wire logic [5:0]  REG_ADDR_I,
  input wire logic [15:0] REG_RDATA_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_release; CONV_HOLD_O && SYNC_N_I; endsequence
  sequence s_start; CONV_START_O && !CONV_HOLD_O; endsequence
  a_gpo_gated: assert property (!GENERAL_OUTPUT_EN_O |->
    !GENERAL_OUTPUT_ZERO_O && !GENERAL_OUTPUT_ONE_O) else $error("output while disabled");
  a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I != 6'h06 |=>
    REG_RVALID_O && REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
  a_reserved_zero: assert property (REG_RVALID_O |->
    REG_RDATA_O[15:14] == 2'h0 && REG_RDATA_O[5:0] == 6'h00) else $error("reserved set");
  a_sync_reset: assert property (MOD_RESET_O |-> $past(!SYNC_N_I))
    else $error("reset without low sync");
  a_alt_no_reset: assert property (MOD_RESET_O |->
    !$past(ALTERNATIVE_SYNC_SELECT_SELECT_I && MULTI_CHAN_I)) else $error("reset in alt mode");
  a_hold_release: assert property (s_release |=> s_start)
    else $error("held conversion not started");
  a_hold_cause: assert property ($rose(CONV_HOLD_O) |->
    $past(SWITCH_DUE_I && !SYNC_N_I && ALTERNATIVE_SYNC_SELECT_SELECT_I && MULTI_CHAN_I))
    else $error("hold without cause");
  a_start_cause: assert property (CONV_START_O |->
    $past(SWITCH_DUE_I || (CONV_HOLD_O && SYNC_N_I))) else $error("start without cause");
  a_drain_low: assert property (ERROR_PIN_OE_O && !ERROR_PULLUP_O |-> !ERROR_PIN_O)
    else $error("open drain drives high");
  a_pullup_drive: assert property (ERROR_PULLUP_O |-> ERROR_PIN_OE_O)
    else $error("pull-up without drive");
  a_err_cause: assert property (ADC_ERROR_O |-> $past(INT_ERROR_I) ||
    $past(INT_ERROR_I, 2) || $past(!ERROR_PIN_I, 2)) else $error("error without source");
endmodule
`default_nettype wire

// ---- dv/gspc_pin_config_tb.sv ----
/*
 bench for the pin function configuration block.
 assumes: core files and pin model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module gspc_pin_config_tb;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, alt = 0, multi = 0, sw = 0, stat = 0;
  logic sync_n = 1, ext_low = 0, int_err = 0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire rvalid, pin, eo, oe, pu, g0, g1, gen, ow, aerr, mres, start, hold;
  wire [6:0] pv = {gen, g1, g0, ow, oe, eo, pu};
  int fail_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  gspc_pin_config gspc_pin_config_inst (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .ALTERNATIVE_SYNC_SELECT_SELECT_I(alt), .MULTI_CHAN_I(multi), .SWITCH_DUE_I(sw),
    .INT_ERROR_I(int_err), .STATUS_ERRORS_I(stat), .SYNC_N_I(sync_n), .ERROR_PIN_I(pin),
    .ERROR_PIN_O(eo), .ERROR_PIN_OE_O(oe), .ERROR_PULLUP_O(pu), .GENERAL_OUTPUT_ZERO_O(g0),
    .GENERAL_OUTPUT_ONE_O(g1), .GENERAL_OUTPUT_EN_O(gen), .OPEN_WIRE_DETECT_EN_O(ow),
    .ADC_ERROR_O(aerr), .MOD_RESET_O(mres), .CONV_START_O(start), .CONV_HOLD_O(hold));
  gspc_pin_env gspc_pin_env_inst (.oe_i(oe), .drive_i(eo), .ext_low_i(ext_low), .pin_o(pin));
  // ---
  // access tasks
  // ---
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1; addr = a; wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  // answer stands for the one cycle after the strobe edge
  task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_rd = 1; addr = a;
    @(negedge clk);
    reg_rd = 0;
    chk("rdata", rdata, e);
    chk("rvalid", rvalid, 1);
  endtask
  task automatic sw_pulse;
    @(negedge clk);
    sw = 1;
    @(negedge clk);
    sw = 0;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---
  // tests
  // ---
  initial begin
    cyc(6);
    rst_n = 1;
    rd_reg(6'h06, 16'h0800);
    chk("pins", pv, 7'h00);
    wr_reg(6'h06, 16'hffff);
    rd_reg(6'h06, 16'h3fc0);
    chk("pins", pv, 7'h7f);
    wr_reg(6'h07, 16'h0000);
    rd_reg(6'h07, 16'h0000);
    rd_reg(6'h06, 16'h3fc0);
    wr_reg(6'h06, 16'h2040);
    cyc(1);
    chk("pins", pv, 7'h50);
    wr_reg(6'h06, 16'h0000);
    cyc(1);
    chk("pins", pv, 7'h00);
    int_err = 1;
    cyc(2);
    chk("err", aerr, 1);
    int_err = 0;
    cyc(2);
    chk("err", aerr, 0);
    wr_reg(6'h06, 16'h0400);
    stat = 1;
    cyc(2);
    chk("drain", {oe, eo, pu, pin}, 4'h8);
    stat = 0;
    cyc(2);
    chk("drain", {oe, pin}, 2'h1);
    wr_reg(6'h06, 16'h0200);
    ext_low = 1;
    cyc(3);
    chk("err", aerr, 1);
    rd_reg(6'h06, 16'h0200);
    ext_low = 0;
    cyc(3);
    rd_reg(6'h06, 16'h0300);
    chk("err", aerr, 0);
    wr_reg(6'h06, 16'h0800);
    sync_n = 0;
    cyc(2);
    chk("mres", mres, 1);
    alt = 1;
    cyc(2);
    chk("mres", mres, 1);
    multi = 1;
    cyc(2);
    chk("mres", mres, 0);
    sw_pulse;
    cyc(1);
    chk("hold", {start, hold}, 2'h1);
    sync_n = 1;
    cyc(1);
    chk("start", {start, hold}, 2'h2);
    cyc(1);
    chk("start", {start, hold}, 2'h0);
    sw_pulse;
    chk("start", start, 1);
    end_of_test;
  end
  // tests need well under 200 cycles
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
endmodule
bind gspc_pin_config gspc_pin_config_sva gspc_pin_config_sva_inst (.*);
`default_nettype wire

// ---- dv/gspc_pin_env.sv ----
/*
 error pin wire model: open-drain line, board pull-up shared by devices.
 assumes: driven from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module gspc_pin_env (
  input  wire logic oe_i, drive_i, ext_low_i,
  output wire logic pin_o
);
  // wired-and line
  // pull-up wins unless any party pulls low
  assign pin_o = !(oe_i && !drive_i) && !ext_low_i;
endmodule
`default_nettype wire
